// >>> usbd_addr_irq_enable.sv
// Purpose: USB device function address, function enable and
//          interrupt enable/disable/mask registers
// Assumes: AHB-Lite slave, single clock, synchronous active-low reset
// Notes:   packet gating follows the function enable bit
//
// Chosen here: the AHB-Lite interface to the registers and the register offsets.

`timescale 1ns/1ps

// Functional notes
// - Address field is zero after reset
// - Function enable bit readable, writing zero disables
// - Packets pass only while function enable set
// - Enable register bits 0-5 enable endpoint interrupts
// - Enable register bit 8 enables suspend interrupt
// - Enable register bit 9 enables resume interrupt
// - Enable register bit 11 enables frame-start interrupt
// - Enable register bit 13 enables wakeup interrupt
// - Disable register mirrors enable register layout
// - Disable register ones disable, zeros ignored
// - Mask view reports accumulated enables and disables
// - Mask bit 12 always reads one
module usbd_addr_irq_enable
    import usbd_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire usbd_evt_type busEvt,
    input wire logic hostPktRx,
    input wire logic hostPktTxReq,
    output logic [6:0] deviceAddressValue,
    output logic endpointFunctionEnable,
    output logic pktRxAccept,
    output logic pktRxRefuse,
    output logic pktTxGrant,
    output logic irq
);

    // Bus side

    usbd_req_type req; // Decoded register access
    logic [31:0] rdWord; // Read mux result
    logic [IRQ_W-1:0] maskView; // Mask as software sees it
    logic [IRQ_W-1:0] statView; // Pending events
    logic [IRQ_W-1:0] evtBits; // Events at bit positions

    // Per-register write strobes
    logic wrFaddr; // Function address write
    logic wrIenSet; // Enable register write
    logic wrIenClr; // Disable register write
    logic wrIstat; // Status write-one-to-clear

    // Vectors handed to the interrupt controller
    logic [IRQ_W-1:0] maskSetVec; // Bits to enable
    logic [IRQ_W-1:0] maskClrVec; // Bits to disable
    logic [IRQ_W-1:0] statClrVec; // Bits to acknowledge

    // Function address state
    logic [6:0] devAddr_r; // Stored function address
    logic fen_r; // Stored function enable

    // Packet gating state
    logic rxAccept_r; // Receive packet taken
    logic rxRefuse_r; // Receive packet dropped
    logic txGrant_r; // Transmit allowed this cycle

    // hsize is not checked: the master only issues word transfers,
    // so a narrow write would land as a full word here.

    // Bus front end

    // Slave port; drives the AHB answer from its own flops
    usbd_ahb_port u_port
    (
        .clk(clk),
        .resetn(resetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hwdata(hwdata),
        .hready(hready),
        .rdata(rdWord),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .req(req)
    );

    // Write decode

    // One strobe per writable offset; the mask view and other offsets do nothing
    assign wrFaddr = req.wr && usbd_hit(req, OFS_FADDR);
    assign wrIenSet = req.wr && usbd_hit(req, OFS_IEN_SET);
    assign wrIenClr = req.wr && usbd_hit(req, OFS_IEN_CLR);
    assign wrIstat = req.wr && usbd_hit(req, OFS_ISTAT);

    // Enable writes: ones enable, zeros leave the mask alone.
    // Covers endpoint bits 0-5 suspend bit 8
    // resume bit 9 frame start bit 11 and
    // wakeup bit 13 the controller drops other bits
    assign maskSetVec = wrIenSet ? req.wdata[IRQ_W-1:0] : '0;

    // Disable writes share the same layout
    // and a zero bit leaves that source as it was
    assign maskClrVec = wrIenClr ? req.wdata[IRQ_W-1:0] : '0;

    // Status acknowledge, one to clear
    assign statClrVec = wrIstat ? req.wdata[IRQ_W-1:0] : '0;

    // Event vector from the USB engine
    assign evtBits = usbd_evt_bits(busEvt);

    // Interrupt controller

    // Mask and status live together so the line sees both at once
    usbd_irq_ctrl #(
        .W(IRQ_W)
    ) u_irq
    (
        .clk(clk),
        .resetn(resetn),
        .maskSet(maskSetVec),
        .maskClr(maskClrVec),
        .statClr(statClrVec),
        .evt(evtBits),
        .maskView(maskView),
        .statView(statView),
        .irq(irq)
    );

    // Function address register

    // Address field; written whenever software asks.
    // Timing against the set-address handshake is software's duty
    // so no check is made here.
    always_ff @(posedge clk)
    begin
        if (!resetn)
            devAddr_r <= DEV_ADDR_RST;
        else if (wrFaddr)
            devAddr_r <= req.wdata[DEVICE_ADDRESS_VALUE_LSB +: DEVICE_ADDRESS_VALUE_W];
    end

    // Function enable bit; zero disables, one enables
    // Firmware is expected to set it after a bus reset
    always_ff @(posedge clk)
    begin
        if (!resetn)
            fen_r <= FEN_RST;
        else if (wrFaddr)
            fen_r <= req.wdata[FEN_POS];
    end

    // Packet gating

    // Receive side: a packet arriving while disabled is refused,
    // so the engine never stores data for a disabled function
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            rxAccept_r <= 1'b0;
            rxRefuse_r <= 1'b0;
        end
        else
        begin
            rxAccept_r <= hostPktRx && fen_r;
            rxRefuse_r <= hostPktRx && !fen_r;
        end
    end

    // Transmit side: level grant, withdrawn one cycle after the enable bit clears.
    // A packet already on the wire is the engine's to finish.
    always_ff @(posedge clk)
    begin
        if (!resetn)
            txGrant_r <= 1'b0;
        else
            txGrant_r <= hostPktTxReq && fen_r;
    end

    // Read mux

    // Offsets outside the map and the write-only pair read as zero
    always_comb
    begin
        rdWord = 32'h0000_0000;
        case (req.ofs)
            // Address and enable, reserved bits zero
            OFS_FADDR:
            begin
                rdWord[DEVICE_ADDRESS_VALUE_LSB +: DEVICE_ADDRESS_VALUE_W] = devAddr_r;
                rdWord[FEN_POS] = fen_r;
            end
            // Write-only registers give nothing back
            OFS_IEN_SET:
                rdWord = 32'h0000_0000;
            OFS_IEN_CLR:
                rdWord = 32'h0000_0000;
            // Mask view, bit 12 already forced high
            OFS_IMASK:
                rdWord[IRQ_W-1:0] = maskView;
            // Pending events
            OFS_ISTAT:
                rdWord[IRQ_W-1:0] = statView;
            // Unmapped: OKAY response, zero data
            default:
                rdWord = 32'h0000_0000;
        endcase
    end

    // Output registers

    // Address and enable copied to ports from their flops
    always_comb
    begin
        deviceAddressValue = devAddr_r;
        endpointFunctionEnable = fen_r;
    end

    // Gating results leave straight from their flops
    always_comb
    begin
        pktRxAccept = rxAccept_r;
        pktRxRefuse = rxRefuse_r;
        pktTxGrant = txGrant_r;
    end

endmodule : usbd_addr_irq_enable

// >>> usbd_pkg.sv
// Purpose: shared constants and carriers for the USB device address
//          and interrupt enable block
// Assumes: 32-bit AHB-Lite register port, one word per register
// Notes:   interrupt vectors are 14 bits, bit n of each register

package usbd_pkg;

    // Register byte offsets, low address bits only
    localparam logic [7:0] OFS_FADDR = 8'h08;
    localparam logic [7:0] OFS_IEN_SET = 8'h10;
    localparam logic [7:0] OFS_IEN_CLR = 8'h14;
    localparam logic [7:0] OFS_IMASK = 8'h18;
    localparam logic [7:0] OFS_ISTAT = 8'h1C;

    // Function address register fields
    localparam int DEVICE_ADDRESS_VALUE_LSB = 0;
    localparam int DEVICE_ADDRESS_VALUE_W = 7;
    localparam int FEN_POS = 8;
    localparam logic [6:0] DEV_ADDR_RST = 7'h00;
    localparam logic FEN_RST = 1'b1;

    // Interrupt vector layout
    localparam int IRQ_W = 14;
    localparam logic [13:0] IRQ_VALID = 14'h2B3F;
    localparam logic [13:0] IRQ_FIXED = 14'h1000;
    localparam logic [13:0] MASK_RST = 14'h0200;

    // Register access taken from the bus
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] ofs;
        logic [31:0] wdata;
    } usbd_req_type;

    // Event pulses from the USB engine
    typedef struct packed {
        logic wakeup;
        logic sof;
        logic resume;
        logic suspend;
        logic [5:0] endpoint;
    } usbd_evt_type;

    // Offset match, used by every write strobe decode
    function automatic logic usbd_hit(input usbd_req_type r, input logic [7:0] ofs);
        usbd_hit = (r.ofs == ofs);
    endfunction : usbd_hit

    // Place events at their register bit positions
    function automatic logic [13:0] usbd_evt_bits(input usbd_evt_type e);
        usbd_evt_bits = {e.wakeup, 1'b0, e.sof, 1'b0, e.resume, e.suspend,
                         2'b00, e.endpoint};
    endfunction : usbd_evt_bits

endpackage : usbd_pkg

// >>> usbd_ahb_port.sv
// Purpose: AHB-Lite slave front end for the register bank
// Assumes: single word transfers; hready is this slave's hreadyout
// Notes:   writes zero wait, reads one wait state; always OKAY

`timescale 1ns/1ps

module usbd_ahb_port
    import usbd_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] rdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output usbd_req_type req
);

    logic dpValid_r; // Data phase in progress
    logic dpWrite_r; // Data phase is a write
    logic [7:0] dpOfs_r; // Latched offset
    logic take; // Address phase accepted

    // NONSEQ or SEQ selects a transfer
    assign take = hsel && htrans[1] && hready;

    // Address phase capture
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            dpValid_r <= 1'b0;
            dpWrite_r <= 1'b0;
            dpOfs_r <= 8'h00;
        end
        else if (take)
        begin
            dpValid_r <= 1'b1;
            dpWrite_r <= hwrite;
            dpOfs_r <= haddr[7:0];
        end
        else if (hready)
            dpValid_r <= 1'b0;
    end

    // Reads stall one cycle so a write just ahead is already visible
    always_ff @(posedge clk)
    begin
        if (!resetn)
            hreadyout <= 1'b1;
        else if (take && !hwrite)
            hreadyout <= 1'b0;
        else
            hreadyout <= 1'b1;
    end

    // Read data sampled in the wait cycle, held until the next read
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            hrdata <= 32'h0000_0000;
            hresp <= 1'b0;
        end
        else if (req.rd)
            hrdata <= rdata;
    end

    // Strobes to the register bank
    assign req.wr = dpValid_r && dpWrite_r && hready;
    assign req.rd = dpValid_r && !dpWrite_r && !hreadyout;
    assign req.ofs = dpOfs_r;
    assign req.wdata = hwdata;

endmodule : usbd_ahb_port

// >>> usbd_irq_ctrl.sv
// Purpose: interrupt mask, sticky status and interrupt line
// Assumes: set and clear vectors are one-cycle write strobes
// Notes:   an event in a clearing cycle survives the clear

`timescale 1ns/1ps

module usbd_irq_ctrl
    import usbd_pkg::*;
#(
    parameter int W = IRQ_W
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [W-1:0] maskSet,
    input wire logic [W-1:0] maskClr,
    input wire logic [W-1:0] statClr,
    input wire logic [W-1:0] evt,
    output logic [W-1:0] maskView,
    output logic [W-1:0] statView,
    output logic irq
);

    logic [W-1:0] mask_r; // Accumulated enables
    logic [W-1:0] stat_r; // Sticky events

    // Set then clear; undefined positions never stored
    always_ff @(posedge clk)
    begin
        if (!resetn)
            mask_r <= MASK_RST;
        else
            mask_r <= (mask_r | (maskSet & IRQ_VALID)) & ~(maskClr & IRQ_VALID);
    end

    // Sticky status, set wins over clear
    always_ff @(posedge clk)
    begin
        if (!resetn)
            stat_r <= '0;
        else
            stat_r <= (stat_r & ~statClr) | (evt & IRQ_VALID);
    end

    // Level interrupt while any enabled event is pending
    always_ff @(posedge clk)
    begin
        if (!resetn)
            irq <= 1'b0;
        else
            irq <= |(stat_r & mask_r & IRQ_VALID);
    end

    // Bit 12 reads as one regardless of writes
    assign maskView = mask_r | IRQ_FIXED;
    assign statView = stat_r;

endmodule : usbd_irq_ctrl

// >>> usbd_checker_properties.sv
// Purpose: port-level checker for the address and irq enable block
// Assumes: one clock domain, synchronous active-low reset
// Notes: keeps a shadow of the mask, built from bus writes only

`timescale 1ns/1ps

module usbd_checker
    import usbd_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire usbd_evt_type busEvt,
    input wire logic hostPktRx,
    input wire logic hostPktTxReq,
    input wire logic [6:0] deviceAddressValue,
    input wire logic endpointFunctionEnable,
    input wire logic pktRxAccept,
    input wire logic pktRxRefuse,
    input wire logic pktTxGrant,
    input wire logic irq
);
    logic take; // Address phase accepted
    logic [7:0] ofs; // Decoded low address bits
    logic [13:0] evtBits; // Events at register bit positions
    logic setPend_r; // Data phase of an enable write
    logic clrPend_r; // Data phase of a disable write
    logic addrPend_r; // Data phase of an address write
    logic [13:0] maskSh_r; // Shadow mask, literals kept apart from the package

    assign take = hsel && htrans[1] && hready;
    assign ofs = haddr[7:0];
    assign evtBits = {busEvt.wakeup, 1'b0, busEvt.sof, 1'b0, busEvt.resume,
                      busEvt.suspend, 2'b00, busEvt.endpoint};

    // Remember which write is in its data phase
    always_ff @(posedge clk)
    begin
        setPend_r <= resetn && take && hwrite && ofs == 8'h10;
        clrPend_r <= resetn && take && hwrite && ofs == 8'h14;
        addrPend_r <= resetn && take && hwrite && ofs == 8'h08;
    end

    // Shadow mask: set wins only on its own register
    always_ff @(posedge clk)
    begin
        if (!resetn)
            maskSh_r <= 14'h0200;
        else if (setPend_r)
            maskSh_r <= maskSh_r | (hwdata[13:0] & 14'h2B3F);
        else if (clrPend_r)
            maskSh_r <= maskSh_r & ~(hwdata[13:0] & 14'h2B3F);
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    a_addr_reset: assert property ($rose(resetn) |-> deviceAddressValue == 7'h00)
        else $error("address not zero after reset");
    a_addr_by_write: assert property ($past(resetn) && $changed(deviceAddressValue)
        |-> $past(addrPend_r) && deviceAddressValue == $past(hwdata[6:0]))
        else $error("address changed without a write");
    a_enable_by_write: assert property ($past(resetn) && $changed(endpointFunctionEnable)
        |-> $past(addrPend_r) && endpointFunctionEnable == $past(hwdata[8]))
        else $error("function enable changed without a write");
    a_rx_accept: assert property (hostPktRx && endpointFunctionEnable
        |=> pktRxAccept && !pktRxRefuse)
        else $error("packet not accepted while enabled");
    a_rx_refuse: assert property (hostPktRx && !endpointFunctionEnable
        |=> pktRxRefuse && !pktRxAccept)
        else $error("packet not refused while disabled");
    a_tx_gate: assert property ($past(resetn) && pktTxGrant
        |-> $past(hostPktTxReq) && $past(endpointFunctionEnable))
        else $error("grant without request and enable");
    a_wo_read_zero: assert property (take && !hwrite && (ofs == 8'h10 || ofs == 8'h14)
        |=> !hreadyout ##1 (hreadyout && hrdata == 32'h0))
        else $error("write-only register read not zero");
    a_mask_read: assert property (take && !hwrite && ofs == 8'h18
        |=> !hreadyout ##1 hrdata == {18'h0, maskSh_r | 14'h1000})
        else $error("mask read differs from enable history");
    a_irq_raise: assert property ((evtBits & maskSh_r) != 14'h0 |-> ##2 irq)
        else $error("enabled event did not raise irq");
endmodule : usbd_checker

bind usbd_addr_irq_enable usbd_checker chk (.*);

// >>> usbd_host_model.sv
// Purpose: host side stand-in driving events and packets
// Assumes: signals change by non-blocking assignment after an edge
// Notes: pulses last exactly one cycle; request is a level

`timescale 1ns/1ps

module usbd_host_model
    import usbd_pkg::*;
(
    input wire logic clk,
    output usbd_evt_type busEvt,
    output logic hostPktRx,
    output logic hostPktTxReq
);
    // Quiet bus at time zero
    initial
    begin
        busEvt = '0;
        hostPktRx = 1'b0;
        hostPktTxReq = 1'b0;
    end

    // One-cycle bus event pulse
    task automatic pulse_evt(input usbd_evt_type e);
        @(posedge clk) busEvt <= e;
        @(posedge clk) busEvt <= '0;
    endtask : pulse_evt

    // Packet strobe; send request held as a level afterwards
    task automatic send_pkt(input logic tx);
        @(posedge clk) hostPktRx <= 1'b1;
        hostPktTxReq <= tx;
        @(posedge clk) hostPktRx <= 1'b0;
    endtask : send_pkt
endmodule : usbd_host_model

// >>> tb_usbd_addr_irq_enable.sv
// Purpose: self-checking bench for the address and irq enable block
// Assumes: AHB-Lite master tasks, host model on the engine side
// Notes: register cases in a row table, odd cases written out after

`timescale 1ns/1ps

module tb_usbd_addr_irq_enable
    import usbd_pkg::*;
;
    typedef struct packed {
        logic [7:0] wOfs;
        logic [31:0] wData;
        logic [7:0] rOfs;
        logic [31:0] rExp;
    } usbd_row_type;

    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2; // Words only
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    usbd_evt_type busEvt;
    logic hostPktRx;
    logic hostPktTxReq;
    logic [6:0] deviceAddressValue;
    logic endpointFunctionEnable;
    logic pktRxAccept;
    logic pktRxRefuse;
    logic pktTxGrant;
    logic irq;
    logic [31:0] rd;
    int failures = 0;
    int testsRun = 0;
    // Write, then read back; mask reads include the fixed bit 12
    usbd_row_type rows [15] = '{
        '{8'h14, 32'hFFFF_FFFF, 8'h18, 32'h0000_1000},
        '{8'h10, 32'h0000_003F, 8'h18, 32'h0000_103F},
        '{8'h10, 32'h0000_0100, 8'h18, 32'h0000_113F},
        '{8'h10, 32'h0000_0200, 8'h18, 32'h0000_133F},
        '{8'h10, 32'h0000_0800, 8'h18, 32'h0000_1B3F},
        '{8'h10, 32'h0000_2000, 8'h18, 32'h0000_3B3F},
        '{8'h10, 32'h0000_0000, 8'h18, 32'h0000_3B3F},
        '{8'h14, 32'h0000_0015, 8'h18, 32'h0000_3B2A},
        '{8'h14, 32'h0000_2A00, 8'h18, 32'h0000_112A},
        '{8'h10, 32'hFFFF_D4C0, 8'h18, 32'h0000_112A},
        '{8'h08, 32'h0000_0155, 8'h08, 32'h0000_0155},
        '{8'h14, 32'h0000_0000, 8'h14, 32'h0000_0000},
        '{8'h10, 32'h0000_0000, 8'h10, 32'h0000_0000},
        '{8'h0C, 32'hFFFF_FFFF, 8'h0C, 32'h0000_0000},
        '{8'h08, 32'h0000_0055, 8'h08, 32'h0000_0055}
    };

    // 50 MHz clock
    always #10 clk = ~clk;

    usbd_addr_irq_enable DUT (.hready(hreadyout), .*);

    usbd_host_model host (
        .clk(clk),
        .busEvt(busEvt),
        .hostPktRx(hostPktRx),
        .hostPktTxReq(hostPktTxReq)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // Reset held low for 16 edges
    task automatic reset_dut();
        resetn <= 1'b0;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
    endtask : reset_dut

    // Single write: address phase until ready, then data until ready
    task automatic ahb_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= 1'b1;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
    endtask : ahb_wr

    // Single read: data taken at the edge that sees ready again
    task automatic ahb_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= 1'b0;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        do @(posedge clk); while (hreadyout !== 1'b1);
        d = hrdata;
    endtask : ahb_rd

    task automatic finish_test();
        $display("tests run %0d failures %0d", testsRun, failures);
        if (failures == 0 && testsRun > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test

    // Hang guard, far beyond the few hundred cycles needed
    initial
    begin
        repeat (5000) @(posedge clk);
        failures++;
        finish_test();
    end

    initial
    begin
        reset_dut();
        foreach (rows[i])
        begin
            ahb_wr(rows[i].wOfs, rows[i].wData);
            ahb_rd(rows[i].rOfs, rd);
            chk(rd, rows[i].rExp);
        end
        $display("test register rows done");
        // Mid-run reset restores address, enable and mask
        reset_dut();
        ahb_rd(8'h08, rd);
        chk(rd, 32'h0000_0100);
        ahb_rd(8'h18, rd);
        chk(rd, 32'h0000_1200);
        chk({31'h0, hresp}, 32'h0);
        $display("test reset done");
        // Disabled function: packet refused, no grant
        ahb_wr(8'h08, 32'h0000_0012);
        host.send_pkt(1'b1);
        #1;
        chk({29'h0, pktRxAccept, pktRxRefuse, pktTxGrant}, 32'h2);
        chk({25'h0, deviceAddressValue}, 32'h12);
        // Enabled again by an address write: accepted and granted
        ahb_wr(8'h08, 32'h0000_0112);
        host.send_pkt(1'b1);
        #1;
        chk({29'h0, pktRxAccept, pktRxRefuse, pktTxGrant}, 32'h5);
        $display("test packet gating done");
        // Resume enabled by reset value raises irq, clear drops it
        host.pulse_evt(10'h080);
        @(posedge clk);
        #1;
        chk({31'h0, irq}, 32'h1);
        ahb_wr(8'h1C, 32'h0000_0200);
        @(posedge clk);
        #1;
        chk({31'h0, irq}, 32'h0);
        // Masked event stays pending but silent
        ahb_wr(8'h14, 32'h0000_0200);
        host.pulse_evt(10'h080);
        repeat (2) @(posedge clk);
        #1;
        chk({31'h0, irq}, 32'h0);
        ahb_rd(8'h1C, rd);
        chk(rd, 32'h0000_0200);
        // Frame-start enabled, then its event
        ahb_wr(8'h10, 32'h0000_0800);
        host.pulse_evt(10'h100);
        @(posedge clk);
        #1;
        chk({31'h0, irq}, 32'h1);
        ahb_wr(8'h1C, 32'h0000_0A00);
        @(posedge clk);
        #1;
        chk({31'h0, irq}, 32'h0);
        $display("test interrupts done");
        finish_test();
    end
endmodule : tb_usbd_addr_irq_enable
